/* pkg/mlt_pkg.sv */
/*
  Shared constants and carriers of the address learning table.
  Assumes a 125 MHz core clock and a 32-bit APB register bus.
*/
package mlt_pkg;
  localparam int          DEPTH      = 8192;
  localparam int          IW         = 13;
  localparam int          NP         = 27;
  localparam int          PW         = 5;
  localparam logic [6:0]  MAX_STATIC = 7'h40;
  localparam int unsigned CLK_NS     = 8;
  localparam int unsigned SEC_NS     = 1000000000;
  localparam int unsigned TICK_CYC   = SEC_NS / CLK_NS;
  localparam logic [31:0] AGE_DEF    = 32'h0000012c;
  localparam logic [31:0] AGE_MIN    = 32'h0000000a;
  localparam logic [31:0] AGE_MAX    = 32'h00989680;
  localparam logic [1:0]  LM_AUTO    = 2'h0;
  localparam logic [1:0]  LM_OFF     = 2'h1;
  localparam logic [1:0]  LM_STATIC  = 2'h2;
  localparam logic [7:0]  A_CTRL     = 8'h00;
  localparam logic [7:0]  A_AGE      = 8'h04;
  localparam logic [7:0]  A_KVID     = 8'h08;
  localparam logic [7:0]  A_KMACL    = 8'h0c;
  localparam logic [7:0]  A_KMACH    = 8'h10;
  localparam logic [7:0]  A_KPORT    = 8'h14;
  localparam logic [7:0]  A_STAT     = 8'h18;
  localparam logic [7:0]  A_RMACL    = 8'h1c;
  localparam logic [7:0]  A_RMACH    = 8'h20;
  localparam logic [7:0]  A_RPORT    = 8'h24;
  localparam logic [7:0]  A_MODEL    = 8'h28;
  localparam logic [7:0]  A_MODEH    = 8'h2c;
  localparam int          C_AGEDIS   = 0;
  localparam int          C_FIRST    = 1;
  localparam int          C_NEXT     = 2;
  localparam int          C_SWR      = 3;
  localparam int          C_SDEL     = 4;
  localparam int          C_FLUSH    = 5;
  localparam int          S_BUSY     = 0;
  localparam int          S_FOUND    = 1;
  localparam int          S_END      = 2;
  localparam int          S_RSTAT    = 3;
  localparam int          S_CNT      = 8;
  localparam int          S_RVID     = 16;

  typedef enum logic [2:0] {
    O_INIT, O_FRAME, O_FIRST, O_NEXT, O_SWR, O_SDEL, O_FLUSH, O_AGE
  } mlt_op_t;

  typedef struct packed {
    logic          valid;
    logic          stat;
    logic          seen;
    logic [11:0]   vid;
    logic [47:0]   mac;
    logic [NP-1:0] ports;
  } mlt_entry_t;

  typedef struct packed {
    logic [PW-1:0] port;
    logic [11:0]   vid;
    logic [47:0]   destination_station_address;
    logic [47:0]   source_station_address;
  } mlt_frame_t;

  typedef struct packed {
    logic          drop;
    logic [NP-1:0] ports;
  } mlt_fwd_t;
endpackage

/* verilog/mlt_table.sv */
/*
  Address learning and forwarding table with APB management.
  Assumes one core clock; the pipeline takes each verdict pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module mlt_table #(
  parameter int unsigned CYC_PER_SEC = mlt_pkg::TICK_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   frm_valid,
  output logic                        frm_ready,
  input  wire mlt_pkg::mlt_frame_t    frm,
  output logic                        fwd_valid,
  output mlt_pkg::mlt_fwd_t           fwd,
  input  wire logic [mlt_pkg::NP-1:0] mode_lock
);
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} mlt_st_t;

  mlt_pkg::mlt_entry_t mem [mlt_pkg::DEPTH];
  mlt_pkg::mlt_entry_t e, wd, res_r, best_r;
  mlt_pkg::mlt_frame_t frm_r;
  mlt_pkg::mlt_op_t    op_r;
  mlt_st_t             st_r;
  logic [mlt_pkg::IW-1:0] idx_r, wi, sa_idx_r, free_idx_r;
  logic [mlt_pkg::NP-1:0] da_ports_r, key_ports_r, oh;
  logic [63:0]  mode_r;
  logic [31:0]  age_time_r, sec_r, tick_r, rd;
  logic [47:0]  key_mac_r;
  logic [11:0]  key_vid_r;
  logic [6:0]   stat_cnt_r;
  logic [5:1]   cmd_r, cmd_set, take;
  logic [1:0]   pmode;
  logic [59:0]  ekey, fkey_da, fkey_sa, kkey, skey;
  logic age_dis_r, age_req_r, sec_tick;
  logic da_hit_r, sa_hit_r, sa_stat_r, free_hit_r, best_hit_r;
  logic res_found_r, res_end_r, we, wr, swr_ok, learn, last;

  assign e       = mem[idx_r];
  assign ekey    = {e.vid, e.mac};
  assign fkey_da = {frm_r.vid, frm_r.destination_station_address};
  assign fkey_sa = {frm_r.vid, frm_r.source_station_address};
  assign kkey    = {key_vid_r, key_mac_r};
  assign skey    = (op_r == mlt_pkg::O_NEXT) ? {res_r.vid, res_r.mac} : kkey;
  assign oh      = mlt_pkg::NP'(1) << frm_r.port;
  assign pmode   = mode_r[{frm_r.port, 1'b0} +: 2];
  assign last    = (idx_r == mlt_pkg::IW'(mlt_pkg::DEPTH - 1));
  assign swr_ok  = (sa_hit_r && sa_stat_r) ||
                   ((stat_cnt_r < mlt_pkg::MAX_STATIC) && (sa_hit_r || free_hit_r));
  assign learn   = (pmode == mlt_pkg::LM_AUTO) && !(sa_hit_r && sa_stat_r) &&
                   (sa_hit_r || free_hit_r);
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > mlt_pkg::A_MODEH || paddr[1:0] != 2'h0);
  assign frm_ready = (st_r == ST_IDLE) && (cmd_r == 5'h00) && !age_req_r;
  assign take    = (st_r == ST_IDLE) ? (cmd_r & (~cmd_r + 5'h01)) : 5'h00;

  // Command pulses from control writes
  always_comb begin
    cmd_set = 5'h00;
    if (wr && paddr == mlt_pkg::A_CTRL) begin
      cmd_set = pwdata[mlt_pkg::C_FLUSH:mlt_pkg::C_FIRST];
    end
  end

  // Single write port of the table
  always_comb begin
    we = 1'b0;
    wi = idx_r;
    wd = e;
    if (st_r == ST_SCAN) begin
      unique case (op_r)
        mlt_pkg::O_INIT: begin
          we       = 1'b1;
          wd.valid = 1'b0;
        end
        mlt_pkg::O_FLUSH: begin
          we       = e.valid && !e.stat;
          wd.valid = 1'b0;
        end
        mlt_pkg::O_AGE: begin
          we       = e.valid && !e.stat;
          wd.seen  = 1'b0;
          wd.valid = e.seen;
        end
        default: we = 1'b0;
      endcase
    end else if (st_r == ST_DONE) begin
      wi = sa_hit_r ? sa_idx_r : free_idx_r;
      unique case (op_r)
        mlt_pkg::O_FRAME: begin
          we = learn;
          wd = '{1'b1, 1'b0, 1'b1, frm_r.vid, frm_r.source_station_address, oh};
        end
        mlt_pkg::O_SWR: begin
          we = swr_ok;
          wd = '{1'b1, 1'b1, 1'b0, key_vid_r, key_mac_r, key_ports_r};
        end
        mlt_pkg::O_SDEL: begin
          we       = sa_hit_r && sa_stat_r;
          wd.valid = 1'b0;
        end
        default: we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[wi] <= wd;
    end
  end

  // Engine sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= ST_SCAN;
      op_r  <= mlt_pkg::O_INIT;
      idx_r <= '0;
      frm_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          idx_r <= '0;
          if (take != 5'h00) begin
            st_r <= ST_SCAN;
            unique case (1'b1)
              take[mlt_pkg::C_FIRST]: op_r <= mlt_pkg::O_FIRST;
              take[mlt_pkg::C_NEXT]:  op_r <= mlt_pkg::O_NEXT;
              take[mlt_pkg::C_SWR]:   op_r <= mlt_pkg::O_SWR;
              take[mlt_pkg::C_SDEL]:  op_r <= mlt_pkg::O_SDEL;
              default:                op_r <= mlt_pkg::O_FLUSH;
            endcase
          end else if (age_req_r) begin
            st_r <= ST_SCAN;
            op_r <= mlt_pkg::O_AGE;
          end else if (frm_valid) begin
            st_r  <= ST_SCAN;
            op_r  <= mlt_pkg::O_FRAME;
            frm_r <= frm;
          end
        end
        ST_SCAN: begin
          idx_r <= idx_r + mlt_pkg::IW'(1);
          if (last) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= (cmd_r & ~take) | cmd_set;
    end
  end

  // Match gathering during the scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      da_hit_r   <= 1'b0;
      da_ports_r <= '0;
      sa_hit_r   <= 1'b0;
      sa_stat_r  <= 1'b0;
      sa_idx_r   <= '0;
      free_hit_r <= 1'b0;
      free_idx_r <= '0;
      best_hit_r <= 1'b0;
      best_r     <= '0;
    end else if (st_r == ST_IDLE) begin
      da_hit_r   <= 1'b0;
      sa_hit_r   <= 1'b0;
      free_hit_r <= 1'b0;
      best_hit_r <= 1'b0;
    end else if (st_r == ST_SCAN) begin
      if (e.valid && ekey == fkey_da && op_r == mlt_pkg::O_FRAME) begin
        da_hit_r   <= 1'b1;
        da_ports_r <= e.ports;
      end
      if (e.valid && ((op_r == mlt_pkg::O_FRAME && ekey == fkey_sa) ||
          ((op_r == mlt_pkg::O_SWR || op_r == mlt_pkg::O_SDEL) && ekey == kkey))) begin
        sa_hit_r  <= 1'b1;
        sa_stat_r <= e.stat;
        sa_idx_r  <= idx_r;
      end
      if (!e.valid && !free_hit_r) begin
        free_hit_r <= 1'b1;
        free_idx_r <= idx_r;
      end
      if (e.valid && (op_r == mlt_pkg::O_FIRST || op_r == mlt_pkg::O_NEXT) &&
          (ekey > skey || (op_r == mlt_pkg::O_FIRST && ekey == skey)) &&
          (!best_hit_r || ekey < {best_r.vid, best_r.mac})) begin
        best_hit_r <= 1'b1;
        best_r     <= e;
      end
    end
  end

  // Management results and static count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r       <= '0;
      res_found_r <= 1'b0;
      res_end_r   <= 1'b0;
      stat_cnt_r  <= '0;
    end else if (st_r == ST_DONE) begin
      unique case (op_r)
        mlt_pkg::O_FIRST, mlt_pkg::O_NEXT: begin
          res_found_r <= best_hit_r;
          res_end_r   <= !best_hit_r;
          if (best_hit_r) begin
            res_r <= best_r;
          end
        end
        mlt_pkg::O_SWR: begin
          res_found_r <= swr_ok;
          if (swr_ok && !(sa_hit_r && sa_stat_r)) begin
            stat_cnt_r <= stat_cnt_r + 7'h01;
          end
        end
        mlt_pkg::O_SDEL: begin
          res_found_r <= sa_hit_r && sa_stat_r;
          if (sa_hit_r && sa_stat_r) begin
            stat_cnt_r <= stat_cnt_r - 7'h01;
          end
        end
        default: res_found_r <= res_found_r;
      endcase
    end
  end

  // Forwarding verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid <= 1'b0;
      fwd       <= '0;
    end else begin
      fwd_valid <= (st_r == ST_DONE) && (op_r == mlt_pkg::O_FRAME);
      if (st_r == ST_DONE && op_r == mlt_pkg::O_FRAME) begin
        fwd.drop  <= (pmode == mlt_pkg::LM_STATIC) && !(sa_hit_r && sa_stat_r);
        fwd.ports <= da_hit_r ? da_ports_r : ~oh;
      end
    end
  end

  // Seconds tick and aging trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r   <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (tick_r == CYC_PER_SEC - 1);
      tick_r   <= (tick_r == CYC_PER_SEC - 1) ? 32'h0 : tick_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r     <= '0;
      age_req_r <= 1'b0;
    end else begin
      if (age_dis_r) begin
        sec_r <= '0;
      end else if (sec_tick) begin
        sec_r <= (sec_r + 32'h1 >= age_time_r) ? 32'h0 : sec_r + 32'h1;
      end
      if (!age_dis_r && sec_tick && sec_r + 32'h1 >= age_time_r) begin
        age_req_r <= 1'b1;
      end else if (st_r == ST_IDLE && take == 5'h00) begin
        age_req_r <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_dis_r   <= 1'b0;
      age_time_r  <= mlt_pkg::AGE_DEF;
      key_vid_r   <= '0;
      key_mac_r   <= '0;
      key_ports_r <= '0;
    end else if (wr) begin
      unique case (paddr)
        mlt_pkg::A_CTRL:  age_dis_r <= pwdata[mlt_pkg::C_AGEDIS];
        mlt_pkg::A_AGE: begin
          if (pwdata >= mlt_pkg::AGE_MIN && pwdata <= mlt_pkg::AGE_MAX) begin
            age_time_r <= pwdata;
          end
        end
        mlt_pkg::A_KVID:  key_vid_r <= pwdata[11:0];
        mlt_pkg::A_KMACL: key_mac_r[31:0] <= pwdata;
        mlt_pkg::A_KMACH: key_mac_r[47:32] <= pwdata[15:0];
        mlt_pkg::A_KPORT: key_ports_r <= pwdata[mlt_pkg::NP-1:0];
        default:          key_vid_r <= key_vid_r;
      endcase
    end
  end

  // Per-port learning mode, sixteen ports a word
  for (genvar p = 0; p < 32; p++) begin : g_mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_r[2*p +: 2] <= mlt_pkg::LM_AUTO;
      end else if (wr && paddr == (p < 16 ? mlt_pkg::A_MODEL : mlt_pkg::A_MODEH) &&
                   (p >= mlt_pkg::NP || !mode_lock[p % mlt_pkg::NP])) begin
        mode_r[2*p +: 2] <= (p < mlt_pkg::NP) ? pwdata[2*(p%16) +: 2] : 2'h0;
      end
    end
  end

  // Read data captured in the setup cycle
  always_comb begin
    rd = 32'h0;
    unique case (paddr)
      mlt_pkg::A_CTRL:  rd[mlt_pkg::C_AGEDIS] = age_dis_r;
      mlt_pkg::A_AGE:   rd = age_time_r;
      mlt_pkg::A_KVID:  rd[11:0] = key_vid_r;
      mlt_pkg::A_KMACL: rd = key_mac_r[31:0];
      mlt_pkg::A_KMACH: rd[15:0] = key_mac_r[47:32];
      mlt_pkg::A_KPORT: rd[mlt_pkg::NP-1:0] = key_ports_r;
      mlt_pkg::A_STAT: begin
        rd[mlt_pkg::S_BUSY]          = (st_r != ST_IDLE) || (cmd_r != 5'h00);
        rd[mlt_pkg::S_FOUND]         = res_found_r;
        rd[mlt_pkg::S_END]           = res_end_r;
        rd[mlt_pkg::S_RSTAT]         = res_r.stat;
        rd[mlt_pkg::S_CNT +: 7]      = stat_cnt_r;
        rd[mlt_pkg::S_RVID +: 12]    = res_r.vid;
      end
      mlt_pkg::A_RMACL: rd = res_r.mac[31:0];
      mlt_pkg::A_RMACH: rd[15:0] = res_r.mac[47:32];
      mlt_pkg::A_RPORT: rd[mlt_pkg::NP-1:0] = res_r.ports;
      mlt_pkg::A_MODEL: rd = mode_r[31:0];
      mlt_pkg::A_MODEH: rd = mode_r[63:32];
      default:          rd = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rd;
    end
  end
endmodule
`default_nettype wire

/* testbench/mlt_table_sva.sv */
/* Port checker of the learning table.
   Bound to every mlt_table instance. */
`timescale 1ns/1ps
`default_nettype none
module mlt_chk #(
  parameter int unsigned CYC_PER_SEC = 20
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   frm_valid,
  input wire logic                   frm_ready,
  input wire mlt_pkg::mlt_frame_t    frm,
  input wire logic                   fwd_valid,
  input wire mlt_pkg::mlt_fwd_t      fwd,
  input wire logic [mlt_pkg::NP-1:0] mode_lock
);
  logic [13:0] lat_r;
  logic        bad_addr;
  assign bad_addr = paddr > 8'h2c || paddr[1:0] != 2'h0;
  // Cycles since the last frame was taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lat_r <= 14'h0;
    else if (frm_valid && frm_ready) lat_r <= 14'h1;
    else if (lat_r != 14'h0) lat_r <= lat_r + 14'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_const_a: assert property (pready) else $error("pready low");
  err_map_a: assert property (pslverr == (psel && penable && bad_addr)) else $error("slverr");
  err_data_a: assert property (psel && !penable && bad_addr |=> prdata == 32'h0)
    else $error("unmapped data");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata");
  verdict_lat_a: assert property (fwd_valid |-> lat_r >= 14'h2001 && lat_r <= 14'h2003)
    else $error("verdict latency");
  verdict_pulse_a: assert property (fwd_valid |=> !fwd_valid) else $error("verdict width");
  one_frame_a: assert property (frm_valid && frm_ready |=> !frm_ready [*8])
    else $error("second frame taken");
  fwd_hold_a: assert property (!fwd_valid |-> $stable(fwd)) else $error("verdict moved");
  init_clear_a: assert property ($rose(presetn) |-> !frm_ready [*8])
    else $error("ready during clear");
endmodule
bind mlt_table mlt_chk #(.CYC_PER_SEC(CYC_PER_SEC)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
  .frm_ready(frm_ready), .frm(frm), .fwd_valid(fwd_valid), .fwd(fwd), .mode_lock(mode_lock));
`default_nettype wire

/* testbench/mlt_pipe_model.sv */
/* Forwarding pipeline model: presents one address set, takes the verdict.
   Assumes go only while no frame is outstanding. */
`timescale 1ns/1ps
`default_nettype none
module mlt_pipe_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                go,
  input  wire mlt_pkg::mlt_frame_t req,
  output logic                     frm_valid,
  input  wire logic                frm_ready,
  output mlt_pkg::mlt_frame_t      frm,
  input  wire logic                fwd_valid,
  input  wire mlt_pkg::mlt_fwd_t   fwd,
  output logic                     got,
  output mlt_pkg::mlt_fwd_t        verdict
);
  // Held until taken, then scrambled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_valid <= 1'b0;
      frm <= '0;
    end else if (go) begin
      frm_valid <= 1'b1;
      frm <= req;
    end else if (frm_valid && frm_ready) begin
      frm_valid <= 1'b0;
      frm <= ~frm;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) got <= 1'b0;
    else got <= fwd_valid;
  end
  always_ff @(posedge pclk) begin
    if (fwd_valid) verdict <= fwd;
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
/* Self-checking bench of the learning table.
   Drives APB and the pipeline model; one clock. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                     frm_valid, frm_ready, fwd_valid, go, got, err_v;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd_v;
  logic [mlt_pkg::NP-1:0]   mode_lock;
  mlt_pkg::mlt_frame_t      frm, req;
  mlt_pkg::mlt_fwd_t        fwd, verdict;
  int                       bad_count, comparisons, cyc;
  localparam logic [47:0]   M_D = 48'h000000000011;
  localparam logic [47:0]   M_S = 48'h000000000022;
  localparam logic [47:0]   M_X = 48'h000000000033;
  localparam logic [47:0]   M_Y = 48'h000000000015;
  mlt_table #(.CYC_PER_SEC(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid), .frm_ready(frm_ready),
    .frm(frm), .fwd_valid(fwd_valid), .fwd(fwd), .mode_lock(mode_lock));
  mlt_pipe_model i_pipe (.pclk(pclk), .presetn(presetn), .go(go), .req(req),
    .frm_valid(frm_valid), .frm_ready(frm_ready), .frm(frm), .fwd_valid(fwd_valid),
    .fwd(fwd), .got(got), .verdict(verdict));
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 99000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons=%0d bad=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input int b);
    apb(1'b1, mlt_pkg::A_CTRL, 32'h1 | (32'h1 << b));
    repeat (4) @(posedge pclk);
    do apb(1'b0, mlt_pkg::A_STAT, 32'h0); while (rd_v[mlt_pkg::S_BUSY] !== 1'b0);
  endtask
  task automatic send(input logic [4:0] p, input logic [47:0] da, input logic [47:0] sa);
    @(posedge pclk);
    req <= {p, 12'h001, da, sa};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    while (got !== 1'b1) @(posedge pclk);
  endtask
  task automatic res(input logic [31:0] st, input logic [47:0] m, input logic [31:0] pt);
    apb(1'b0, mlt_pkg::A_STAT, 32'h0);
    chk(rd_v & 32'h0fff7f0e, st);
    apb(1'b0, mlt_pkg::A_RMACL, 32'h0);
    chk(rd_v, m[31:0]);
    apb(1'b0, mlt_pkg::A_RPORT, 32'h0);
    chk(rd_v, pt);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h0;
    {paddr, pwdata, req, cyc, bad_count, comparisons} = '0;
    mode_lock = 27'h0000002;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, mlt_pkg::A_CTRL, 32'h1);
    apb(1'b0, mlt_pkg::A_CTRL, 32'h0);
    chk(rd_v, 32'h00000001);
    apb(1'b1, mlt_pkg::A_AGE, 32'h00000009);
    apb(1'b0, mlt_pkg::A_AGE, 32'h0);
    chk(rd_v, 32'h0000012c);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    apb(1'b1, mlt_pkg::A_MODEL, 32'h00000046);
    apb(1'b0, mlt_pkg::A_MODEL, 32'h0);
    chk(rd_v, 32'h00000042);
    $display("test registers done");
    apb(1'b1, mlt_pkg::A_KVID, 32'h1);
    apb(1'b1, mlt_pkg::A_KMACL, M_S[31:0]);
    apb(1'b1, mlt_pkg::A_KMACH, {16'h0, M_S[47:32]});
    apb(1'b1, mlt_pkg::A_KPORT, 32'h5);
    cmd(mlt_pkg::C_SWR);
    chk(rd_v & 32'h00007f02, 32'h00000102);
    send(5'h02, M_S, M_D);
    chk({4'h0, verdict}, 32'h00000005);
    send(5'h00, M_X, M_X);
    chk({31'h0, verdict.drop}, 32'h1);
    send(5'h03, M_D, M_Y);
    chk({4'h0, verdict}, 32'h00000004);
    $display("test forwarding done");
    apb(1'b1, mlt_pkg::A_KMACL, 32'h0);
    apb(1'b1, mlt_pkg::A_KMACH, 32'h0);
    cmd(mlt_pkg::C_FIRST);
    res(32'h00010102, M_D, 32'h4);
    cmd(mlt_pkg::C_NEXT);
    res(32'h0001010a, M_S, 32'h5);
    $display("test walk done");
    cmd(mlt_pkg::C_FLUSH);
    cmd(mlt_pkg::C_FIRST);
    res(32'h0001010a, M_S, 32'h5);
    cmd(mlt_pkg::C_NEXT);
    chk(rd_v & 32'h6, 32'h4);
    $display("test flush done");
    apb(1'b1, mlt_pkg::A_KMACL, M_S[31:0]);
    cmd(mlt_pkg::C_SDEL);
    chk(rd_v & 32'h00007f02, 32'h00000002);
    $display("test delete done");
    final_report();
  end
endmodule
`default_nettype wire
